// ==== include/cbnz_pkg.sv ====
package cbnz_pkg;

    // Instruction word layout.
    localparam int          CBNZ_IW_W        = 16;
    localparam int          CBNZ_PC_W        = 21;
    localparam int          CBNZ_OFF_W       = 8;
    localparam logic [7:0]  CBNZ_OPC_BNZ     = 8'hE1;
    localparam logic [7:0]  CBNZ_OPC_BRANCH_IF_OVERFLOW_CLEAR    = 8'hE5;
    localparam int          CBNZ_OPC_MSB     = 15;
    localparam int          CBNZ_OPC_LSB     = 8;
    localparam logic [20:0] CBNZ_WORD_BYTES  = 21'h000002;

    // Status flag positions in the status byte.
    localparam int          CBNZ_ZERO_BIT    = 2;
    localparam int          CBNZ_OVF_BIT     = 3;

    // Quarter-phase encodings Q1 to Q4.
    localparam logic [1:0]  CBNZ_Q1          = 2'h0;
    localparam logic [1:0]  CBNZ_Q2          = 2'h1;
    localparam logic [1:0]  CBNZ_Q3          = 2'h2;
    localparam logic [1:0]  CBNZ_Q4          = 2'h3;

    typedef enum logic [1:0] {
        CBNZ_ACT_NOP,
        CBNZ_ACT_DECODE,
        CBNZ_ACT_READ_LIT,
        CBNZ_ACT_PROCESS
    } cbnz_act_t;

    typedef enum {
        CBNZ_ST_EXEC,
        CBNZ_ST_FLUSH
    } cbnz_state_t;

    // Instruction presented by fetch at Q1 of an instruction cycle.
    typedef struct packed {
        logic                 valid;
        logic [15:0]          word;
        logic [20:0]          addr;
    } cbnz_fetch_t;

    // Program counter update sent back to the fetch unit.
    typedef struct packed {
        logic                 wr;
        logic                 taken;
        logic                 flush;
        logic [20:0]          target;
    } cbnz_pc_t;

endpackage : cbnz_pkg

// ==== core/cbnz_branch.sv ====
// Function
// RULE_01 - Opcode upper byte 1110 0001 decodes as branch_if_zero_clear; low byte is offset.
// RULE_02 - Offset is signed -128..127 and doubled into a byte displacement.
// RULE_03 - Taken target is branch address plus 2 plus twice the offset.
// RULE_04 - Branch taken only when Zero reads 0, else fall through to next word.
// RULE_05 - No status flag changes, taken or not.
// RULE_06 - Not taken costs one cycle; taken costs two with fetch flushed.
// RULE_07 - Taken first cycle: decode Q1, read literal Q2, process Q3, write PC Q4.
// RULE_08 - Second cycle of a taken branch does nothing in Q1 to Q4.
// RULE_09 - Not taken: decode, read, process, then no PC write in Q4.
// RULE_10 - branch_if_overflow_clear with Overflow 1 advances two bytes to next word.
// RULE_11 - Opcode 1110 0101 is branch_if_overflow_clear, taken when Overflow is 0.
// RULE_12 - Instruction is one 16-bit word; fall through is two bytes on.
`timescale 1ns/1ns

module cbnz_branch
    import cbnz_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Instruction from fetch and live status byte
    input  wire cbnz_fetch_t fetch_in,
    input  wire logic [7:0]  status_in,
    // Program counter update to fetch
    output cbnz_pc_t         pc_out,
    // Phase activity and flag write strobe
    output logic [1:0]       phase_out,
    output cbnz_act_t        act_out,
    output logic             busy_out,
    output logic             status_we_out,
    output logic [7:0]       status_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Quarter-phase counter: each instruction cycle is four clocks Q1..Q4.

    logic [1:0]  phase_q;
    cbnz_state_t state_q;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            phase_q <= CBNZ_Q1;
        else
            phase_q <= phase_q + 2'h1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decode, latched at Q1 of an execute cycle.

    logic        is_bnz;
    logic        is_branch_if_overflow_clear;
    logic        ins_q;
    logic        take_q;
    logic [7:0]  lit_q;
    logic [20:0] base_q;
    logic [20:0] disp_d;
    logic [20:0] target_q;

    // [RULE_01] [RULE_11]
    assign is_bnz  = fetch_in.word[CBNZ_OPC_MSB:CBNZ_OPC_LSB] == CBNZ_OPC_BNZ;
    assign is_branch_if_overflow_clear = fetch_in.word[CBNZ_OPC_MSB:CBNZ_OPC_LSB] == CBNZ_OPC_BRANCH_IF_OVERFLOW_CLEAR;

    // Branch presence is latched at Q1 of an execute cycle; the flush cycle ignores fetch.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            ins_q <= 1'b0;
        else if (phase_q == CBNZ_Q1 && state_q == CBNZ_ST_EXEC)
            ins_q <= fetch_in.valid && (is_bnz || is_branch_if_overflow_clear);     // [RULE_01] [RULE_11]
    end

    // Flags are sampled at decode; later writers cannot change the outcome.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            take_q <= 1'b0;
        else if (phase_q == CBNZ_Q1 && state_q == CBNZ_ST_EXEC)
            take_q <= (is_bnz && !status_in[CBNZ_ZERO_BIT])     // [RULE_04]
                   || (is_branch_if_overflow_clear && !status_in[CBNZ_OVF_BIT]);    // [RULE_11] [RULE_10]
    end

    // The counter has already moved past the branch word when the target is formed.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            base_q <= '0;
        else if (phase_q == CBNZ_Q1 && state_q == CBNZ_ST_EXEC)
            base_q <= fetch_in.addr + CBNZ_WORD_BYTES;          // [RULE_12] [RULE_03]
    end

    // Literal read in Q2.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            lit_q <= '0;
        else if (phase_q == CBNZ_Q2 && state_q == CBNZ_ST_EXEC)
            lit_q <= fetch_in.word[CBNZ_OFF_W-1:0];             // [RULE_01]
    end

    // Sign-extend and double the offset, one bit of the displacement at a time. [RULE_02]
    for (genvar b = 0; b < CBNZ_PC_W; b++)
    begin : g_disp
        if (b == 0)
        begin : g_zero
            assign disp_d[b] = 1'b0;
        end
        else if (b <= CBNZ_OFF_W)
        begin : g_lit
            assign disp_d[b] = lit_q[b-1];
        end
        else
        begin : g_sign
            assign disp_d[b] = lit_q[CBNZ_OFF_W-1];
        end
    end

    // Target computed in Q3. [RULE_03]
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            target_q <= '0;
        else if (phase_q == CBNZ_Q3 && state_q == CBNZ_ST_EXEC)
            target_q <= base_q + disp_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cycle sequencing: a taken branch adds one flush cycle.

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            state_q <= CBNZ_ST_EXEC;
        else if (phase_q == CBNZ_Q4)
        begin
            unique case (state_q)
                CBNZ_ST_EXEC:
                    if (ins_q && take_q)
                        state_q <= CBNZ_ST_FLUSH;               // [RULE_06]
                CBNZ_ST_FLUSH:
                    state_q <= CBNZ_ST_EXEC;                    // [RULE_06]
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Program counter update, launched at the Q4 edge of an execute cycle.

    logic        pc_wr_q;
    logic        pc_flush_q;
    logic        pc_taken_q;
    logic [20:0] pc_target_q;
    logic        retire_d;
    logic        fire_d;

    // A decoded branch retires at Q4; only a taken one writes the counter.
    assign retire_d = phase_q == CBNZ_Q4 && state_q == CBNZ_ST_EXEC && ins_q;
    assign fire_d   = retire_d && take_q;

    // Write strobe: one clock, in Q4 of the first cycle, taken only.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            pc_wr_q <= 1'b0;
        else
            pc_wr_q <= fire_d;                                  // [RULE_07] [RULE_09]
    end

    // Flush strobe travels with the write so fetch drops the prefetched word.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            pc_flush_q <= 1'b0;
        else
            pc_flush_q <= fire_d;                               // [RULE_06]
    end

    // Outcome of the last retired branch; held until the next one retires.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            pc_taken_q <= 1'b0;
        else if (retire_d)
            pc_taken_q <= take_q;                               // [RULE_04]
    end

    // Target: the computed jump, or the next word when the branch falls through.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            pc_target_q <= '0;
        else if (fire_d)
            pc_target_q <= target_q;                            // [RULE_03]
        else if (retire_d)
            pc_target_q <= base_q;                              // [RULE_10] [RULE_12]
    end

    assign pc_out = '{wr: pc_wr_q, taken: pc_taken_q, flush: pc_flush_q, target: pc_target_q};

    ////////////////////////////////////////////////////////////////////////////
    // Phase activity follows the current phase one clock later, aligned with pc_out.

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            phase_out <= CBNZ_Q1;
        else
            phase_out <= phase_q;
    end

    // Busy marks the discarded second cycle of a taken branch.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            busy_out <= 1'b0;
        else
            busy_out <= state_q == CBNZ_ST_FLUSH;               // [RULE_06] [RULE_08]
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            act_out <= CBNZ_ACT_NOP;
        else if (state_q == CBNZ_ST_FLUSH)
            act_out <= CBNZ_ACT_NOP;                            // [RULE_08]
        else
        begin
            unique case (phase_q)
                CBNZ_Q1: act_out <= CBNZ_ACT_DECODE;            // [RULE_07]
                CBNZ_Q2: act_out <= CBNZ_ACT_READ_LIT;          // [RULE_07]
                CBNZ_Q3: act_out <= CBNZ_ACT_PROCESS;           // [RULE_07]
                CBNZ_Q4: act_out <= CBNZ_ACT_NOP;               // [RULE_09]
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flags are never written back: the strobe is held low in every cycle.

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            status_we_out <= 1'b0;
        else
            status_we_out <= 1'b0;                              // [RULE_05]
    end

    // Each status bit is passed on one clock late, untouched.
    for (genvar s = 0; s < $bits(status_in); s++)
    begin : g_status
        always_ff @(posedge clk)
        begin
            if (sys_rst)
                status_out[s] <= 1'b0;
            else
                status_out[s] <= status_in[s];                  // [RULE_05]
        end
    end

endmodule : cbnz_branch

// ==== tb/cbnz_branch_asserts.sv ====
`timescale 1ns/1ns

module cbnz_branch_asserts
    import cbnz_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // Observed ports
    input wire cbnz_fetch_t fetch_in,
    input wire logic [7:0]  status_in,
    input wire cbnz_pc_t    pc_out,
    input wire logic [1:0]  phase_out,
    input wire cbnz_act_t   act_out,
    input wire logic        busy_out,
    input wire logic        status_we_out,
    input wire logic [7:0]  status_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_lit_then_process;
        act_out == CBNZ_ACT_READ_LIT ##1 act_out == CBNZ_ACT_PROCESS;
    endsequence
    sequence s_flush_cycle;
        busy_out [*4] ##1 !busy_out;
    endsequence

    AST_FLUSH_WITH_WR:
        assert property (pc_out.wr == pc_out.flush) else $error("flush differs from wr");
    AST_WR_ONE_CLOCK:
        assert property (pc_out.wr |=> !pc_out.wr) else $error("wr wider than one clock");
    AST_WR_ONLY_TAKEN:
        assert property (pc_out.wr |-> pc_out.taken) else $error("wr without taken");
    AST_WR_IN_Q4:
        assert property (pc_out.wr |-> phase_out == CBNZ_Q4) else $error("wr outside Q4");
    AST_FLUSH_FOUR:
        assert property (pc_out.wr |=> s_flush_cycle) else $error("flush cycle length wrong");
    AST_NOP_WHEN_BUSY:
        assert property (busy_out |-> act_out == CBNZ_ACT_NOP) else $error("activity in flush");
    AST_PHASE_ORDER:
        assert property (act_out == CBNZ_ACT_DECODE |-> phase_out == CBNZ_Q1 ##0
            (1'b1 ##1 s_lit_then_process)) else $error("phase activity order wrong");
    AST_NO_FLAG_WRITE:
        assert property (!status_we_out) else $error("status written");
    AST_STATUS_KEPT:
        assert property (!$past(sys_rst) |-> status_out == $past(status_in))
            else $error("status copy altered");
endmodule : cbnz_branch_asserts

bind cbnz_branch cbnz_branch_asserts cbnz_branch_asserts_inst (.clk(clk), .sys_rst(sys_rst),
    .fetch_in(fetch_in), .status_in(status_in), .pc_out(pc_out), .phase_out(phase_out),
    .act_out(act_out), .busy_out(busy_out), .status_we_out(status_we_out),
    .status_out(status_out));

// ==== tb/conditional_branch_not_zero_test.sv ====
`timescale 1ns/1ns

module conditional_branch_not_zero_test;
    import cbnz_pkg::*;
    logic        clk;
    logic        sys_rst;
    cbnz_fetch_t fetch_in;
    logic [7:0]  status_in;
    cbnz_pc_t    pc_out;
    logic [1:0]  phase_out;
    cbnz_act_t   act_out;
    logic        busy_out;
    logic        status_we_out;
    logic [7:0]  status_out;
    int          fails, checks_done, cyc, wr_cnt, exp_wr;
    logic [31:0] rnd;
    logic [20:0] exp_tgt;
    logic        exp_tk;

    cbnz_branch cbnz_branch_inst (.clk(clk), .sys_rst(sys_rst), .fetch_in(fetch_in),
        .status_in(status_in), .pc_out(pc_out), .phase_out(phase_out), .act_out(act_out),
        .busy_out(busy_out), .status_we_out(status_we_out), .status_out(status_out));

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // The ceiling is about twice the longest expected run.
    always @(posedge clk)
    begin
        cyc++;
        if (pc_out.wr === 1'b1) wr_cnt++;
        if (cyc > 1000)
        begin
            fails++;
            report_and_stop();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
    endfunction : lfsr

    task automatic check(input logic ok);
        checks_done++;
        if (ok !== 1'b1)
        begin
            fails++;
            $display("CHECK FAILED at %0t: pc update wrong", $time);
        end
    endtask : check

    // The word is held for the whole cycle, also through the flush cycle, so a valid
    // branch sits at Q1 of every flush and must be ignored.
    task automatic run_one(input logic [7:0] opc, input logic [7:0] off, input logic [7:0] st,
                           input logic [20:0] a);
        logic tk;
        fetch_in = '{1'b1, {opc, off}, a};
        status_in = st;
        repeat (2) @(posedge clk);
        #1;
        check(pc_out.target === exp_tgt && pc_out.taken === exp_tk && wr_cnt == exp_wr);
        tk = (opc == CBNZ_OPC_BNZ && !st[CBNZ_ZERO_BIT]) || (opc == CBNZ_OPC_BRANCH_IF_OVERFLOW_CLEAR && !st[CBNZ_OVF_BIT]);
        if (opc == CBNZ_OPC_BNZ || opc == CBNZ_OPC_BRANCH_IF_OVERFLOW_CLEAR)
        begin
            exp_tk = tk;
            exp_tgt = a + CBNZ_WORD_BYTES + (tk ? 21'(2 * int'($signed(off))) : 21'h0);
        end
        exp_wr += int'(tk);
        repeat (tk ? 6 : 2) @(posedge clk);
        #1;
    endtask : run_one

    task automatic report_and_stop();
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {fails, checks_done, cyc, wr_cnt, exp_wr} = '0;
        {sys_rst, fetch_in, status_in, exp_tgt, exp_tk} = {1'b1, 68'h0};
        rnd = 32'h9DBB;
        repeat (10) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        for (int i = 0; i < 60; i++)
        begin
            rnd = lfsr(rnd);
            run_one(i % 3 == 0 ? CBNZ_OPC_BNZ : (i % 3 == 1 ? CBNZ_OPC_BRANCH_IF_OVERFLOW_CLEAR : rnd[31:24]),
                    i < 4 ? (i[1] ? 8'h7F : 8'h80) : rnd[7:0], i < 4 ? 8'h00 : rnd[15:8],
                    {rnd[30:11], 1'b0});
        end
        run_one(8'h00, 8'h00, 8'h00, 21'h0);
        report_and_stop();
    end
endmodule : conditional_branch_not_zero_test
